/* ssir_cfg.svh */
// Offsets, field positions and reset values of the SCSI status and interrupt registers
// What this block does
// - Parity sampled on leading REQ edge as initiator, leading ACK edge as target
// - In wide transfers the upper data byte is also checked, Data phase only
// - Enabled parity error latches bit 2 until cleared, then shows last byte
// - With parity checking disabled the parity error bit reads zero
// - Phase change bit 1 sets on change to unexpected phase; write one clears
// - Initiator only: request bit 0 sets on REQ edge async, offset above one sync
// - Request bit clears on outgoing ACK edge async, zero offset sync, or write of one
// - Overrun bit 7 sets on REQ after max offset before ACK, sync initiator reads
// - Overrun bit clears only through the channel clear control
// - Five-bit field shows FIFO byte count, zero empty, sixteen full
// - Sync status holds FIFO-offset difference high, offset count low
// - Test bit 2 inverts the direction choosing which counter is read
// - Fast test bit 1 runs counters at the clock rate
// - Carry-force bit 0 forces carry between stages of the counters
// - Mask A bits let matching first status bits raise the interrupt
// - Mask B bits let matching second status bits raise the interrupt
// - Bus line registers return the live 16 data lines
// - Address shadow loads on host address write, counts, saves, zero at reset
// - Selection timer is a 256, 256, 10, 2, 2, 2 chain, each stage visible
// - On reselection own ID is removed and the other ID encoded in bits 7-4
// - Single-bit flag bit 3 set for one ID bit on low byte, clear for two
// - Auto-flush disable bit 5 stops automatic flush; manual flush still works
`ifndef SSIR_CFG_SVH
`define SSIR_CFG_SVH
// ----------------------------------------
// Register offsets
// ----------------------------------------
`define SSIR_OFS_STATUS_B 5'h0c
`define SSIR_OFS_FIFO 5'h0d
`define SSIR_OFS_SYNC 5'h0e
`define SSIR_OFS_TEST 5'h0f
`define SSIR_OFS_MASK_A 5'h10
`define SSIR_OFS_MASK_B 5'h11
`define SSIR_OFS_BUS_LO 5'h12
`define SSIR_OFS_BUS_HI 5'h13
`define SSIR_OFS_SHADDR0 5'h14
`define SSIR_OFS_SHADDR1 5'h15
`define SSIR_OFS_SHADDR2 5'h16
`define SSIR_OFS_SHADDR3 5'h17
`define SSIR_OFS_TIMER 5'h18
`define SSIR_OFS_SELECTING_DEVICE_ID 5'h19
`define SSIR_OFS_BLKCTL 5'h1f
// ----------------------------------------
// Field positions and masks
// ----------------------------------------
`define SSIR_B_PERR 2
`define SSIR_B_PHCHG 1
`define SSIR_B_REQ 0
`define SSIR_T_HSEL 2
`define SSIR_T_FAST 1
`define SSIR_T_CARRY 0
`define SSIR_BLK_FLUSHDIS 5
`define SSIR_TEST_MASK 8'h07
`define SSIR_MASK_A_MASK 8'h7f
`define SSIR_BLK_MASK 8'h20
`define SSIR_RESET_VAL 8'h00
`endif

/* ssir_pkg.sv */
// Types shared by the SCSI status and interrupt register block
package ssir_pkg;
  typedef logic [2:0] ssir_phase_t;
  typedef struct packed {
    logic initiator;
    logic sync_mode;
    logic direction;
    logic wide_transfer_setting;
    logic parity_check_enable;
    logic ack_out;
  } ssir_xfer_ctl_t;
  typedef struct packed {
    logic [3:0] max_offset;
    logic [3:0] current_offset_count;
    logic [3:0] fifo_offset_difference;
    logic [4:0] fifo_byte_count;
  } ssir_offset_t;
  typedef struct packed {
    logic req_s1, req_s2, req_d;
    logic ack_s1, ack_s2, ack_d;
    logic [15:0] dat_s1, dat_s2;
    logic [1:0] par_s1, par_s2;
    ssir_phase_t ph_s1, ph_s2, ph_d;
    logic perr, last_bad, phchg, request_pending_flag, overrun;
    logic ackout_d, pmis_d, done_d;
    logic [7:0] test, mask_a, mask_b;
    logic flush_dis;
    logic [31:0] host_address_shadow, saved;
    logic [7:0] st1, st2;
    logic [3:0] st3;
    logic st4, st5, st6;
    logic [3:0] selecting_device_id;
    logic single_id_flag;
    logic [7:0] rdata;
    logic irq, flush, sel_rqak;
  } ssir_state_t;
endpackage

/* ssir_top.sv */
// SCSI status, interrupt enable, test and monitor registers of one channel
//
// Decided for this implementation: the plain strobed port.
`include "ssir_cfg.svh"
module ssir_top #(
  parameter int STAGE3_DIV = 10
) (
  // Clock and reset
  input wire logic I_CLK,
  input wire logic I_RESET,
  // Register port
  input wire logic [4:0] I_ADDR,
  input wire logic [7:0] I_WDATA,
  input wire logic I_WR,
  input wire logic I_RD,
  output logic [7:0] O_RDATA,
  // SCSI bus pins
  input wire logic I_SCSI_REQ,
  input wire logic I_SCSI_ACK,
  input wire logic [15:0] I_BUS_DATA_LINE,
  input wire logic [1:0] I_BUS_PARITY,
  input wire ssir_pkg::ssir_phase_t I_BUS_PHASE,
  // Channel state from neighbouring logic
  input wire ssir_pkg::ssir_xfer_ctl_t I_XFER_CTL,
  input wire ssir_pkg::ssir_offset_t I_OFFSET,
  input wire ssir_pkg::ssir_phase_t I_EXPECTED_PHASE,
  input wire logic I_CHANNEL_CLEAR,
  input wire logic [6:0] I_SCSI_STATUS_A,
  input wire logic [4:0] I_STATUS_B_UPPER,
  input wire logic I_PHASE_MISMATCH,
  input wire logic I_TRANSFER_DONE,
  input wire logic I_MANUAL_FLUSH,
  // Address shadow, timer and selection events
  input wire logic I_HADDR_WR,
  input wire logic [31:0] I_HADDR,
  input wire logic I_BYTE_XFER,
  input wire logic I_SAVE_PTRS,
  input wire logic I_SEL_TIMER_EN,
  input wire logic I_TIMER_TICK,
  input wire logic I_SELECTION_IN,
  input wire logic [3:0] I_OWN_ID,
  // Outputs
  output logic O_SCSI_INTERRUPT_LINE,
  output logic O_FLUSH,
  output logic O_SEL_HANDSHAKE_CNT,
  output logic O_COUNTER_FAST_TEST,
  output logic O_CARRY_FORCE_TEST,
  output logic [31:0] O_SAVED_ADDR
);
  import ssir_pkg::*;

  // Stage three counter is four bits wide
  if (STAGE3_DIV < 2 || STAGE3_DIV > 16) begin
    $error("STAGE3_DIV must be 2 to 16");
  end

  // ----------------------------------------
  // Helpers
  // ----------------------------------------
  function automatic logic [3:0] enc16(input logic [15:0] v);
    enc16 = 4'h0;
    for (int i = 0; i < 16; i++) begin
      if (v[i]) begin
        enc16 = 4'(i);
      end
    end
  endfunction

  function automatic logic [3:0] ones8(input logic [7:0] v);
    ones8 = 4'h0;
    for (int i = 0; i < 8; i++) begin
      ones8 = ones8 + {3'h0, v[i]};
    end
  endfunction

  // Byte-wise increment; force makes each byte step on its own
  function automatic logic [31:0] inc_bytes(input logic [31:0] v, input logic force_c);
    logic c;
    c = 1'b1;
    inc_bytes = v;
    for (int b = 0; b < 4; b++) begin
      if (c || force_c) begin
        inc_bytes[8*b +: 8] = v[8*b +: 8] + 8'h01;
      end
      c = c && (v[8*b +: 8] == 8'hff);
    end
  endfunction

  ssir_state_t s;
  ssir_state_t n;

  // ----------------------------------------
  // Bus events
  // ----------------------------------------
  logic req_rise, ack_rise, strobe, data_phase, bad_lo, bad_hi, par_bad;
  logic ackout_rise, wr_status_b, phase_event, req_set, req_clr, ovr_set;
  logic tick, c2, c3, c4, c5, c6;
  logic [7:0] status_b, timer_view;
  logic [15:0] other_ids;

  assign req_rise = s.req_s2 & ~s.req_d;
  assign ack_rise = s.ack_s2 & ~s.ack_d;
  assign strobe = I_XFER_CTL.initiator ? req_rise : ack_rise;
  assign data_phase = (s.ph_s2[2:1] == 2'b00);
  // Odd parity: nine bits with an even count of ones are bad
  assign bad_lo = ~^{s.dat_s2[7:0], s.par_s2[0]};
  assign bad_hi = I_XFER_CTL.wide_transfer_setting & data_phase & ~^{s.dat_s2[15:8], s.par_s2[1]};
  assign par_bad = bad_lo | bad_hi;
  assign ackout_rise = I_XFER_CTL.ack_out & ~s.ackout_d;
  assign wr_status_b = I_WR && (I_ADDR == `SSIR_OFS_STATUS_B);
  assign phase_event = (s.ph_s2 != s.ph_d) && (s.ph_s2 != I_EXPECTED_PHASE);
  assign req_set = I_XFER_CTL.initiator &&
    (I_XFER_CTL.sync_mode ? (I_OFFSET.current_offset_count > 4'h1) : req_rise);
  assign req_clr = (I_XFER_CTL.sync_mode ? (I_OFFSET.current_offset_count == 4'h0) : ackout_rise) ||
    (wr_status_b && I_WDATA[`SSIR_B_REQ]);
  assign ovr_set = I_XFER_CTL.sync_mode && I_XFER_CTL.initiator && !I_XFER_CTL.direction &&
    (I_OFFSET.current_offset_count == I_OFFSET.max_offset) && req_rise && !I_XFER_CTL.ack_out;
  assign status_b = {I_STATUS_B_UPPER, s.perr, s.phchg, s.request_pending_flag};
  assign other_ids = s.dat_s2 & ~(16'h0001 << I_OWN_ID);

  // ----------------------------------------
  // Selection timer chain
  // ----------------------------------------
  // Slow tick in normal use; fast test runs it from the clock
  assign tick = I_SEL_TIMER_EN & (s.test[`SSIR_T_FAST] | I_TIMER_TICK);
  assign c2 = s.test[`SSIR_T_CARRY] | (s.st1 == 8'hff);
  assign c3 = s.test[`SSIR_T_CARRY] | (c2 & (s.st2 == 8'hff));
  assign c4 = s.test[`SSIR_T_CARRY] | (c3 & (s.st3 == 4'(STAGE3_DIV - 1)));
  assign c5 = s.test[`SSIR_T_CARRY] | (c4 & s.st4);
  assign c6 = s.test[`SSIR_T_CARRY] | (c5 & s.st5);
  assign timer_view = {2'b00, s.st6, s.st5, s.st4,
    (s.st3 >= 4'(STAGE3_DIV / 2)), s.st2[7], s.st1[7]};

  // ----------------------------------------
  // Next state
  // ----------------------------------------
  always_comb begin
    n = s;
    n.req_s1 = I_SCSI_REQ;
    n.req_s2 = s.req_s1;
    n.req_d = s.req_s2;
    n.ack_s1 = I_SCSI_ACK;
    n.ack_s2 = s.ack_s1;
    n.ack_d = s.ack_s2;
    n.dat_s1 = I_BUS_DATA_LINE;
    n.dat_s2 = s.dat_s1;
    n.par_s1 = I_BUS_PARITY;
    n.par_s2 = s.par_s1;
    n.ph_s1 = I_BUS_PHASE;
    n.ph_s2 = s.ph_s1;
    n.ph_d = s.ph_s2;
    n.ackout_d = I_XFER_CTL.ack_out;
    n.pmis_d = I_PHASE_MISMATCH;
    n.done_d = I_TRANSFER_DONE;

    // Parity error: latched, clear restores last byte status
    if (strobe) begin
      n.last_bad = par_bad;
    end
    if (wr_status_b && I_WDATA[`SSIR_B_PERR]) begin
      n.perr = strobe ? par_bad : s.last_bad;
    end
    if (strobe && par_bad) begin
      n.perr = 1'b1;
    end
    if (!I_XFER_CTL.parity_check_enable) begin
      n.perr = 1'b0;
    end

    if (wr_status_b && I_WDATA[`SSIR_B_PHCHG]) begin
      n.phchg = 1'b0;
    end
    if (phase_event) begin
      n.phchg = 1'b1;
    end

    if (req_clr) begin
      n.request_pending_flag = 1'b0;
    end
    if (req_set) begin
      n.request_pending_flag = 1'b1;
    end

    if (I_CHANNEL_CLEAR) begin
      n.overrun = 1'b0;
    end
    if (ovr_set) begin
      n.overrun = 1'b1;
    end

    // Register writes
    if (I_WR) begin
      case (I_ADDR)
        `SSIR_OFS_TEST: n.test = I_WDATA & `SSIR_TEST_MASK;
        `SSIR_OFS_MASK_A: n.mask_a = I_WDATA & `SSIR_MASK_A_MASK;
        `SSIR_OFS_MASK_B: n.mask_b = I_WDATA;
        `SSIR_OFS_BLKCTL: n.flush_dis = I_WDATA[`SSIR_BLK_FLUSHDIS];
        default: n.test = s.test;
      endcase
    end

    // Address shadow
    if (I_HADDR_WR) begin
      n.host_address_shadow = I_HADDR;
    end else if (I_BYTE_XFER || s.test[`SSIR_T_FAST]) begin
      n.host_address_shadow = inc_bytes(s.host_address_shadow, s.test[`SSIR_T_CARRY]);
    end
    if (I_SAVE_PTRS) begin
      n.saved = s.host_address_shadow;
    end

    // Selection timer stages
    if (!I_SEL_TIMER_EN) begin
      n.st1 = 8'h00;
      n.st2 = 8'h00;
      n.st3 = 4'h0;
      n.st4 = 1'b0;
      n.st5 = 1'b0;
      n.st6 = 1'b0;
    end else if (tick) begin
      n.st1 = s.st1 + 8'h01;
      if (c2) begin
        n.st2 = s.st2 + 8'h01;
      end
      if (c3) begin
        n.st3 = (s.st3 == 4'(STAGE3_DIV - 1)) ? 4'h0 : s.st3 + 4'h1;
      end
      if (c4) begin
        n.st4 = ~s.st4;
      end
      if (c5) begin
        n.st5 = ~s.st5;
      end
      if (c6) begin
        n.st6 = ~s.st6;
      end
    end

    // Selecting device ID
    if (I_SELECTION_IN) begin
      n.selecting_device_id = enc16(other_ids);
      n.single_id_flag = (ones8(s.dat_s2[7:0]) == 4'h1);
    end

    // Read port: data valid only in the cycle after the strobe
    n.rdata = `SSIR_RESET_VAL;
    if (I_RD) begin
      case (I_ADDR)
        `SSIR_OFS_STATUS_B: n.rdata = status_b;
        `SSIR_OFS_FIFO: n.rdata = {s.overrun, 2'b00, I_OFFSET.fifo_byte_count};
        `SSIR_OFS_SYNC: n.rdata = {I_OFFSET.fifo_offset_difference, I_OFFSET.current_offset_count};
        `SSIR_OFS_TEST: n.rdata = s.test;
        `SSIR_OFS_MASK_A: n.rdata = s.mask_a;
        `SSIR_OFS_MASK_B: n.rdata = s.mask_b;
        `SSIR_OFS_BUS_LO: n.rdata = s.dat_s2[7:0];
        `SSIR_OFS_BUS_HI: n.rdata = s.dat_s2[15:8];
        `SSIR_OFS_SHADDR0: n.rdata = s.host_address_shadow[7:0];
        `SSIR_OFS_SHADDR1: n.rdata = s.host_address_shadow[15:8];
        `SSIR_OFS_SHADDR2: n.rdata = s.host_address_shadow[23:16];
        `SSIR_OFS_SHADDR3: n.rdata = s.host_address_shadow[31:24];
        `SSIR_OFS_TIMER: n.rdata = timer_view;
        `SSIR_OFS_SELECTING_DEVICE_ID: n.rdata = {s.selecting_device_id, s.single_id_flag, 3'b000};
        `SSIR_OFS_BLKCTL: n.rdata = {2'b00, s.flush_dis, 5'h00};
        default: n.rdata = `SSIR_RESET_VAL;
      endcase
    end

    // Interrupt from either mask
    n.irq = (|(I_SCSI_STATUS_A & s.mask_a[6:0])) | (|(status_b & s.mask_b));

    // Flush on a rising mismatch or done unless disabled
    n.flush = I_MANUAL_FLUSH || (!s.flush_dis &&
      ((I_PHASE_MISMATCH && !s.pmis_d) || (I_TRANSFER_DONE && !s.done_d)));

    n.sel_rqak = I_XFER_CTL.direction ^ s.test[`SSIR_T_HSEL];
  end

  always_ff @(posedge I_CLK) begin
    if (I_RESET) begin
      s <= '0;
    end else begin
      s <= n;
    end
  end

  // ----------------------------------------
  // Outputs
  // ----------------------------------------
  assign O_RDATA = s.rdata;
  assign O_SCSI_INTERRUPT_LINE = s.irq;
  assign O_FLUSH = s.flush;
  assign O_SEL_HANDSHAKE_CNT = s.sel_rqak;
  assign O_COUNTER_FAST_TEST = s.test[`SSIR_T_FAST];
  assign O_CARRY_FORCE_TEST = s.test[`SSIR_T_CARRY];
  assign O_SAVED_ADDR = s.saved;

  // ----------------------------------------
  // Checks
  // ----------------------------------------
  AST_PERR_OFF: assert property (@(posedge I_CLK) disable iff (I_RESET)
    !I_XFER_CTL.parity_check_enable |=> !s.perr)
    else $error("parity flag set while checking disabled");
  AST_PERR_LATCH: assert property (@(posedge I_CLK) disable iff (I_RESET)
    (strobe && par_bad && I_XFER_CTL.parity_check_enable) |=> s.perr)
    else $error("parity error not latched");
  AST_PHCHG_SET: assert property (@(posedge I_CLK) disable iff (I_RESET)
    phase_event |=> s.phchg)
    else $error("phase change not flagged");
  AST_REQ_ASYNC: assert property (@(posedge I_CLK) disable iff (I_RESET)
    (I_XFER_CTL.initiator && !I_XFER_CTL.sync_mode && req_rise) |=> s.request_pending_flag)
    else $error("request flag missed on REQ edge");
  AST_REQ_SYNC_CLR: assert property (@(posedge I_CLK) disable iff (I_RESET)
    (I_XFER_CTL.sync_mode && I_OFFSET.current_offset_count == 4'h0) |=> !s.request_pending_flag)
    else $error("request flag kept at zero offset");
  AST_OVR_HOLD: assert property (@(posedge I_CLK) disable iff (I_RESET)
    (s.overrun && !I_CHANNEL_CLEAR) |=> s.overrun)
    else $error("overrun lost without channel clear");
  AST_IRQ_B: assert property (@(posedge I_CLK) disable iff (I_RESET)
    (s.perr && s.mask_b[`SSIR_B_PERR]) |=> O_SCSI_INTERRUPT_LINE)
    else $error("enabled parity status gave no interrupt");
  AST_IRQ_OFF: assert property (@(posedge I_CLK) disable iff (I_RESET)
    (s.mask_a == 8'h00 && s.mask_b == 8'h00) |=> !O_SCSI_INTERRUPT_LINE)
    else $error("interrupt with both masks clear");
  AST_BUS_READ: assert property (@(posedge I_CLK) disable iff (I_RESET)
    (I_RD && I_ADDR == `SSIR_OFS_BUS_LO) |=> (O_RDATA == $past(s.dat_s2[7:0])))
    else $error("bus low read mismatch");
  AST_SHADOW_LOAD: assert property (@(posedge I_CLK) disable iff (I_RESET)
    I_HADDR_WR |=> (s.host_address_shadow == $past(I_HADDR)))
    else $error("shadow not loaded from host address");
  AST_NO_AUTOFLUSH: assert property (@(posedge I_CLK) disable iff (I_RESET)
    (s.flush_dis && !I_MANUAL_FLUSH) |=> !O_FLUSH)
    else $error("flush while auto flush disabled");
  AST_SINGLE_ID_FLAG: assert property (@(posedge I_CLK) disable iff (I_RESET)
    (I_SELECTION_IN && ones8(s.dat_s2[7:0]) == 4'h2) |=> !s.single_id_flag)
    else $error("single id flag set with two ids");
  AST_REQ_CLR_WRITE: assert property (@(posedge I_CLK) disable iff (I_RESET)
    (wr_status_b && I_WDATA[`SSIR_B_REQ] && !req_set) |=> !s.request_pending_flag)
    else $error("request flag kept after clear write");
  AST_FLUSH_MANUAL: assert property (@(posedge I_CLK) disable iff (I_RESET)
    I_MANUAL_FLUSH |=> O_FLUSH)
    else $error("manual flush not forwarded");
  AST_OVR_SET: assert property (@(posedge I_CLK) disable iff (I_RESET)
    ovr_set |=> s.overrun)
    else $error("overrun not flagged");

endmodule

/* ssir_scsi_model.sv */
// Behavioural SCSI target that drives REQ, data, parity and phase
module ssir_scsi_model (
  // Clock
  input wire logic clk,
  // Bus lines
  output logic req,
  output logic ack,
  output logic [15:0] data,
  output logic [1:0] parity,
  output ssir_pkg::ssir_phase_t phase
);
  timeunit 1ns;
  timeprecision 1ps;
  import ssir_pkg::*;
  initial begin
    req = 1'b0;
    ack = 1'b0;
    data = 16'h0000;
    parity = 2'h0;
    phase = 3'h0;
  end
  // Odd parity per byte; bad flips the chosen byte parities
  task automatic put(input logic [15:0] d, input logic [1:0] bad);
    @(posedge clk);
    data <= d;
    parity <= {~^d[15:8], ~^d[7:0]} ^ bad;
  endtask
  // Data stable across the whole REQ pulse, terminators negate after
  task automatic send(input logic [15:0] d, input logic [1:0] bad);
    put(d, bad);
    @(posedge clk);
    req <= 1'b1;
    repeat (4) @(posedge clk);
    req <= 1'b0;
    repeat (4) @(posedge clk);
    data <= 16'h0000;
    parity <= 2'h0;
  endtask
  task automatic set_phase(input ssir_phase_t p);
    @(posedge clk);
    phase <= p;
    repeat (5) @(posedge clk);
  endtask
  // Initiator side: ACK pulse over stable data
  task automatic send_ack(input logic [15:0] d, input logic [1:0] bad);
    put(d, bad);
    @(posedge clk);
    ack <= 1'b1;
    repeat (4) @(posedge clk);
    ack <= 1'b0;
    repeat (4) @(posedge clk);
  endtask
endmodule

/* scsi_status_interrupt_regs_tb_top.sv */
// Register-level testbench of the SCSI status and interrupt block
module scsi_status_interrupt_regs_tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  import ssir_pkg::*;
  // ----------------------------------------
  // Signals
  // ----------------------------------------
  logic I_CLK = 1'b0;
  logic I_RESET, I_WR, I_RD, I_CHANNEL_CLEAR, I_PHASE_MISMATCH, I_TRANSFER_DONE, I_MANUAL_FLUSH;
  logic I_HADDR_WR, I_BYTE_XFER, I_SAVE_PTRS, I_SEL_TIMER_EN, I_TIMER_TICK, I_SELECTION_IN;
  logic irq, flush, sel_cnt, fast, carry, req, ack;
  logic [4:0] I_ADDR, stat_b_hi;
  logic [7:0] I_WDATA, O_RDATA;
  logic [6:0] I_SCSI_STATUS_A;
  logic [3:0] I_OWN_ID;
  logic [31:0] I_HADDR, O_SAVED_ADDR;
  logic [15:0] bus_data;
  logic [1:0] bus_par;
  ssir_xfer_ctl_t xc;
  ssir_offset_t ofs;
  ssir_phase_t I_EXPECTED_PHASE, bus_phase;
  logic [4:0] ro_a[9] = '{5'h0c, 5'h0d, 5'h0e, 5'h0f, 5'h10, 5'h11, 5'h18, 5'h19, 5'h00};
  logic [4:0] rw_a[4] = '{5'h0f, 5'h10, 5'h11, 5'h1f};
  logic [7:0] rw_e[4] = '{8'h07, 8'h7f, 8'hff, 8'h20};
  int n_errors = 0;
  int tests_run = 0;
  int n_flush = 0;
  int cycles = 0;
  always #12.5 I_CLK = ~I_CLK;
  ssir_top #(.STAGE3_DIV(10)) DUT (
    .I_CLK(I_CLK), .I_RESET(I_RESET), .I_ADDR(I_ADDR), .I_WDATA(I_WDATA), .I_WR(I_WR),
    .I_RD(I_RD), .O_RDATA(O_RDATA), .I_SCSI_REQ(req), .I_SCSI_ACK(ack),
    .I_BUS_DATA_LINE(bus_data), .I_BUS_PARITY(bus_par), .I_BUS_PHASE(bus_phase),
    .I_XFER_CTL(xc), .I_OFFSET(ofs), .I_EXPECTED_PHASE(I_EXPECTED_PHASE),
    .I_CHANNEL_CLEAR(I_CHANNEL_CLEAR), .I_SCSI_STATUS_A(I_SCSI_STATUS_A), .I_STATUS_B_UPPER(stat_b_hi),
    .I_PHASE_MISMATCH(I_PHASE_MISMATCH), .I_TRANSFER_DONE(I_TRANSFER_DONE),
    .I_MANUAL_FLUSH(I_MANUAL_FLUSH), .I_HADDR_WR(I_HADDR_WR), .I_HADDR(I_HADDR),
    .I_BYTE_XFER(I_BYTE_XFER), .I_SAVE_PTRS(I_SAVE_PTRS), .I_SEL_TIMER_EN(I_SEL_TIMER_EN),
    .I_TIMER_TICK(I_TIMER_TICK), .I_SELECTION_IN(I_SELECTION_IN), .I_OWN_ID(I_OWN_ID),
    .O_SCSI_INTERRUPT_LINE(irq), .O_FLUSH(flush), .O_SEL_HANDSHAKE_CNT(sel_cnt),
    .O_COUNTER_FAST_TEST(fast), .O_CARRY_FORCE_TEST(carry), .O_SAVED_ADDR(O_SAVED_ADDR)
  );
  ssir_scsi_model bus (
    .clk(I_CLK), .req(req), .ack(ack), .data(bus_data), .parity(bus_par), .phase(bus_phase)
  );
  // ----------------------------------------
  // Tasks
  // ----------------------------------------
  task automatic chk(input string name, input logic [31:0] seen, input logic [31:0] exp);
    tests_run++;
    if (seen !== exp) begin
      n_errors++;
      $display("mismatch %s expected %h seen %h", name, exp, seen);
    end
  endtask
  task automatic wr(input logic [4:0] a, input logic [7:0] d);
    @(posedge I_CLK);
    I_ADDR <= a;
    I_WDATA <= d;
    I_WR <= 1'b1;
    @(posedge I_CLK);
    I_WR <= 1'b0;
  endtask
  // Read data stand only in the cycle after the strobe
  task automatic rchk(input logic [4:0] a, input logic [7:0] exp);
    @(posedge I_CLK);
    I_ADDR <= a;
    I_RD <= 1'b1;
    @(posedge I_CLK);
    I_RD <= 1'b0;
    #1;
    chk($sformatf("reg %h", a), O_RDATA, exp);
  endtask
  task automatic print_verdict();
    $display("checks %0d, mismatches %0d", tests_run, n_errors);
    if (n_errors == 0 && tests_run > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask
  // Flush pulse counter and hang guard, well above the ~470 cycles needed
  always @(posedge I_CLK) begin
    if (flush === 1'b1) n_flush++;
    cycles++;
    if (cycles == 4000) begin
      n_errors++;
      print_verdict();
    end
  end
  // ----------------------------------------
  // Tests
  // ----------------------------------------
  initial begin
    {I_RESET, I_WR, I_RD, I_CHANNEL_CLEAR, I_PHASE_MISMATCH, I_TRANSFER_DONE} = 6'h20;
    {I_MANUAL_FLUSH, I_HADDR_WR, I_BYTE_XFER, I_SAVE_PTRS, I_SEL_TIMER_EN, I_TIMER_TICK} = 6'h00;
    {I_SELECTION_IN, I_ADDR, I_WDATA, I_SCSI_STATUS_A, I_OWN_ID, I_HADDR, stat_b_hi} = '0;
    xc = '0;
    ofs = '0;
    I_EXPECTED_PHASE = 3'h0;
    repeat (4) @(posedge I_CLK);
    I_RESET <= 1'b0;
    foreach (ro_a[i]) rchk(ro_a[i], 8'h00);
    foreach (rw_a[i]) begin
      wr(rw_a[i], 8'hff);
      rchk(rw_a[i], rw_e[i]);
    end
    wr(5'h0d, 8'hff);
    rchk(5'h0d, 8'h00);
    chk("handshake select", sel_cnt, 1'b1);
    xc.direction <= 1'b1;
    repeat (3) @(posedge I_CLK);
    chk("handshake select", sel_cnt, 1'b0);
    chk("fast test", fast, 1'b1);
    chk("carry force", carry, 1'b1);
    wr(5'h0f, 8'h00);
    $display("test registers done");
    // Auto flush held off while the disable bit is set
    I_PHASE_MISMATCH <= 1'b1;
    repeat (4) @(posedge I_CLK);
    chk("flush count", n_flush, 0);
    I_MANUAL_FLUSH <= 1'b1;
    @(posedge I_CLK);
    I_MANUAL_FLUSH <= 1'b0;
    repeat (3) @(posedge I_CLK);
    chk("flush count", n_flush, 1);
    wr(5'h1f, 8'h00);
    I_TRANSFER_DONE <= 1'b1;
    repeat (4) @(posedge I_CLK);
    chk("flush count", n_flush, 2);
    ofs <= '{4'h8, 4'h3, 4'ha, 5'h10};
    rchk(5'h0d, 8'h10);
    rchk(5'h0e, 8'ha3);
    bus.put(16'ha55a, 2'b00);
    repeat (3) @(posedge I_CLK);
    rchk(5'h12, 8'h5a);
    rchk(5'h13, 8'ha5);
    bus.send(16'h0000, 2'b00);
    rchk(5'h0c, 8'h00);
    $display("test status and flush done");
    xc.initiator <= 1'b1;
    bus.send(16'h0000, 2'b00);
    rchk(5'h0c, 8'h01);
    wr(5'h0c, 8'h01);
    rchk(5'h0c, 8'h00);
    bus.send(16'h0000, 2'b00);
    xc.ack_out <= 1'b1;
    repeat (3) @(posedge I_CLK);
    rchk(5'h0c, 8'h00);
    xc.ack_out <= 1'b0;
    wr(5'h10, 8'h00);
    wr(5'h11, 8'h00);
    bus.send(16'h0000, 2'b00);
    chk("interrupt", irq, 1'b0);
    wr(5'h11, 8'h01);
    repeat (3) @(posedge I_CLK);
    chk("interrupt", irq, 1'b1);
    stat_b_hi <= 5'h10;
    wr(5'h11, 8'h80);
    repeat (3) @(posedge I_CLK);
    chk("interrupt", irq, 1'b1);
    rchk(5'h0c, 8'h81);
    stat_b_hi <= 5'h00;
    wr(5'h11, 8'h00);
    I_SCSI_STATUS_A <= 7'h40;
    wr(5'h10, 8'h40);
    repeat (3) @(posedge I_CLK);
    chk("interrupt", irq, 1'b1);
    wr(5'h10, 8'h3f);
    repeat (3) @(posedge I_CLK);
    chk("interrupt", irq, 1'b0);
    wr(5'h0c, 8'h01);
    $display("test request and interrupt done");
    xc.parity_check_enable <= 1'b1;
    bus.send(16'h00c3, 2'b01);
    rchk(5'h0c, 8'h05);
    bus.send(16'h0000, 2'b00);
    rchk(5'h0c, 8'h05);
    wr(5'h0c, 8'h05);
    rchk(5'h0c, 8'h00);
    xc.parity_check_enable <= 1'b0;
    bus.send(16'h0000, 2'b01);
    rchk(5'h0c, 8'h01);
    xc.parity_check_enable <= 1'b1;
    xc.wide_transfer_setting <= 1'b1;
    bus.send(16'h0100, 2'b10);
    rchk(5'h0c, 8'h05);
    bus.send(16'h0000, 2'b00);
    wr(5'h0c, 8'h05);
    I_EXPECTED_PHASE <= 3'h2;
    bus.set_phase(3'h2);
    bus.send(16'h0100, 2'b10);
    rchk(5'h0c, 8'h01);
    wr(5'h0c, 8'h01);
    bus.set_phase(3'h3);
    rchk(5'h0c, 8'h02);
    wr(5'h0c, 8'h02);
    rchk(5'h0c, 8'h00);
    xc.initiator <= 1'b0;
    bus.send_ack(16'h0000, 2'b01);
    rchk(5'h0c, 8'h04);
    wr(5'h0c, 8'h04);
    rchk(5'h0c, 8'h04);
    xc.parity_check_enable <= 1'b0;
    xc.initiator <= 1'b1;
    $display("test parity and phase done");
    xc.sync_mode <= 1'b1;
    ofs.current_offset_count <= 4'h2;
    repeat (3) @(posedge I_CLK);
    rchk(5'h0c, 8'h01);
    ofs.current_offset_count <= 4'h0;
    repeat (2) @(posedge I_CLK);
    rchk(5'h0c, 8'h00);
    xc.direction <= 1'b0;
    ofs.max_offset <= 4'h4;
    ofs.current_offset_count <= 4'h4;
    bus.send(16'h0000, 2'b00);
    rchk(5'h0d, 8'h90);
    I_CHANNEL_CLEAR <= 1'b1;
    @(posedge I_CLK);
    I_CHANNEL_CLEAR <= 1'b0;
    rchk(5'h0d, 8'h10);
    $display("test sync done");
    I_HADDR <= 32'h12345678;
    I_HADDR_WR <= 1'b1;
    @(posedge I_CLK);
    I_HADDR_WR <= 1'b0;
    repeat (2) begin
      @(posedge I_CLK);
      I_BYTE_XFER <= 1'b1;
      @(posedge I_CLK);
      I_BYTE_XFER <= 1'b0;
    end
    for (int k = 0; k < 4; k++) rchk(5'(20 + k), 8'(32'h1234567a >> (8 * k)));
    I_SAVE_PTRS <= 1'b1;
    @(posedge I_CLK);
    I_SAVE_PTRS <= 1'b0;
    repeat (2) @(posedge I_CLK);
    chk("saved address", O_SAVED_ADDR, 32'h1234567a);
    I_OWN_ID <= 4'h7;
    bus.put(16'h0088, 2'b00);
    repeat (3) @(posedge I_CLK);
    I_SELECTION_IN <= 1'b1;
    @(posedge I_CLK);
    I_SELECTION_IN <= 1'b0;
    rchk(5'h19, 8'h30);
    bus.put(16'h0008, 2'b00);
    repeat (3) @(posedge I_CLK);
    I_SELECTION_IN <= 1'b1;
    @(posedge I_CLK);
    I_SELECTION_IN <= 1'b0;
    rchk(5'h19, 8'h38);
    // Fast count with forced carry: every shadow byte steps each clock
    wr(5'h0f, 8'h03);
    I_HADDR <= 32'h0;
    I_HADDR_WR <= 1'b1;
    @(posedge I_CLK);
    I_HADDR_WR <= 1'b0;
    wr(5'h0f, 8'h00);
    for (int k = 0; k < 4; k++) rchk(5'(20 + k), 8'h02);
    // Held tick steps the first stage once per clock
    I_SEL_TIMER_EN <= 1'b1;
    I_TIMER_TICK <= 1'b1;
    repeat (130) @(posedge I_CLK);
    I_TIMER_TICK <= 1'b0;
    rchk(5'h18, 8'h01);
    $display("test shadow, id and timer done");
    print_verdict();
  end
endmodule
